// ==== common/alu_map.svh ====
/*
 * constants for the real-multiply / bcd-divide arithmetic unit.
 * assumes inclusion by the package and the unit; definitions only.
 */
`ifndef ALU_MAP_SVH
`define ALU_MAP_SVH
`define ALU_WORD_W      16
`define ALU_ACC_W       32
`define ALU_BCD_DIGITS  8
`define ALU_DIV_STEPS   32
`define ALU_EXP_MAX     8'hFF
`define ALU_EXP_ZERO    8'h00
`define ALU_EXP_BIAS    10'h07F
`define ALU_NIB_MAX     4'h9
`define ALU_SIGN_BIT    31
`endif

// ==== common/alu_pkg.sv ====
/*
 * types shared by the arithmetic unit and its sequencer.
 * assumes alu_map.svh is reachable on the include path.
 */
`include "alu_map.svh"
package alu_pkg;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_REAL_MUL,
        OP_BCD_DIV,
        OP_BCD_DIV_WIDE
    } alu_op_e;

    // operand as fetched by the sequencer
    typedef struct packed {
        logic [`ALU_WORD_W-1:0] lo_word;
        logic [`ALU_WORD_W-1:0] hi_word;
        logic                   is_const;
        logic                   via_pointer;
        logic                   pointer_bad;
    } operand_s;

    // discrete status flags
    typedef struct packed {
        logic operand_overflow_flag;
        logic result_zero_flag;
        logic result_negative_flag;
        logic invalid_pointer_flag;
        logic valid_real_flag;
        logic sign_error_flag;
        logic float_underflow_flag;
        logic bad_number_flag;
    } flags_s;
endpackage : alu_pkg

// ==== design/real_mul_bcd_div_alu.sv ====
/*
 * arithmetic unit: ieee single real multiply, 16- and 32-bit bcd divide.
 * assumes the sequencer holds op and operand stable until o_done and
 * issues a new op only while o_busy is low.
 */
`timescale 1ns/10ps
`include "alu_map.svh"
module real_mul_bcd_div_alu
    import alu_pkg::*;
#(
    parameter int ACC_W = `ALU_ACC_W
)(
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    input  wire logic             i_start,
    input  wire alu_op_e          i_op,
    input  wire operand_s         i_operand,
    input  wire logic             i_acc_load,
    input  wire logic [ACC_W-1:0] i_acc_load_value,
    output logic                  o_busy,
    output logic                  o_done,
    output logic [ACC_W-1:0]      o_acc,
    output logic [ACC_W-1:0]      o_stack0,
    output flags_s                o_flags
);
    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIN} state_e;

    function automatic logic is_bcd(input logic [ACC_W-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `ALU_BCD_DIGITS; i++)
            if (v[i*4 +: 4] > `ALU_NIB_MAX) ok = 1'b0;
        return ok;
    endfunction : is_bcd

    function automatic logic [ACC_W-1:0] bcd_to_bin(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] r;
        r = '0;
        for (int i = `ALU_BCD_DIGITS - 1; i >= 0; i--)
            r = ACC_W'(r * 10) + ACC_W'(v[i*4 +: 4]);
        return r;
    endfunction : bcd_to_bin

    function automatic logic [ACC_W-1:0] bin_to_bcd(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] r;
        logic [ACC_W-1:0] t;
        r = '0;
        t = v;
        for (int i = 0; i < `ALU_BCD_DIGITS; i++)
        begin
            r[i*4 +: 4] = 4'(t % 10);
            t = t / 10;
        end
        return r;
    endfunction : bin_to_bcd

    // true when the word is an ieee nan or infinity
    function automatic logic not_real(input logic [ACC_W-1:0] v);
        return v[30:23] == `ALU_EXP_MAX;
    endfunction : not_real

    state_e           state_q, state_d;
    logic [ACC_W-1:0] acc_q, acc_d;
    logic [ACC_W-1:0] stk_q, stk_d;
    logic [ACC_W-1:0] num_q, num_d;
    logic [ACC_W-1:0] den_q, den_d;
    logic [ACC_W-1:0] rem_q, rem_d;
    logic [5:0]       cnt_q, cnt_d;
    flags_s           flg_q, flg_d;
    logic             done_q, done_d;

    logic [ACC_W-1:0] opnd;
    logic [47:0]      mant_prod;
    logic signed [9:0] exp_sum;
    logic [ACC_W-1:0] fmul;
    logic             fmul_uf;
    logic [ACC_W:0]   rem_sh;

    // operand assembly: low-addressed word is the low half
    always_comb
    begin
        opnd = {i_operand.hi_word, i_operand.lo_word};
        if (i_op == OP_BCD_DIV)
            opnd = {{`ALU_WORD_W{1'b0}}, i_operand.lo_word};
    end

    // single-cycle float multiply, truncating; subnormals flush to zero
    always_comb
    begin
        mant_prod = {1'b1, acc_q[22:0]} * {1'b1, opnd[22:0]};
        exp_sum   = 10'(acc_q[30:23]) + 10'(opnd[30:23]) - `ALU_EXP_BIAS;
        if (mant_prod[47])
            exp_sum = exp_sum + 10'sd1;
        fmul    = '0;
        fmul_uf = 1'b0;
        fmul[`ALU_SIGN_BIT] = acc_q[`ALU_SIGN_BIT] ^ opnd[`ALU_SIGN_BIT];
        if (acc_q[30:23] == `ALU_EXP_ZERO || opnd[30:23] == `ALU_EXP_ZERO)
            fmul[30:0] = '0;
        else if (exp_sum <= 10'sd0)
        begin
            fmul[30:0] = '0;
            fmul_uf    = 1'b1;
        end
        else if (exp_sum >= 10'sd255)
            fmul[30:23] = `ALU_EXP_MAX;
        else
        begin
            fmul[30:23] = exp_sum[7:0];
            fmul[22:0]  = mant_prod[47] ? mant_prod[46:24] : mant_prod[45:23];
        end
    end

    assign rem_sh = {rem_q, num_q[ACC_W-1]};

    // sequencing: real multiply in one cycle, divide as restoring loop
    always_comb
    begin
        state_d = state_q;
        acc_d   = acc_q;
        stk_d   = stk_q;
        num_d   = num_q;
        den_d   = den_q;
        rem_d   = rem_q;
        cnt_d   = cnt_q;
        flg_d   = flg_q;
        done_d  = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (i_acc_load)
                    acc_d = i_acc_load_value;
                if (i_start && i_op == OP_REAL_MUL)
                begin
                    flg_d.invalid_pointer_flag = i_operand.via_pointer
                                                 && i_operand.pointer_bad;
                    flg_d.sign_error_flag      = 1'b0;
                    flg_d.bad_number_flag      = not_real(acc_q) || not_real(opnd);
                    if (!flg_d.bad_number_flag && !flg_d.invalid_pointer_flag)
                    begin
                        acc_d = fmul;
                        flg_d.float_underflow_flag = fmul_uf;
                    end
                    else
                        flg_d.float_underflow_flag = 1'b0;
                    flg_d.valid_real_flag = !not_real(acc_d);
                    state_d = ST_FIN;
                end
                else if (i_start && (i_op == OP_BCD_DIV || i_op == OP_BCD_DIV_WIDE))
                begin
                    // wide form ignores the pointer path entirely
                    flg_d.invalid_pointer_flag = (i_op == OP_BCD_DIV)
                        && i_operand.via_pointer && i_operand.pointer_bad;
                    flg_d.bad_number_flag = !is_bcd(acc_q) || !is_bcd(opnd);
                    flg_d.operand_overflow_flag = (opnd == '0)
                        || (bcd_to_bin(opnd) > bcd_to_bin(acc_q));
                    if (flg_d.bad_number_flag || opnd == '0 || flg_d.invalid_pointer_flag)
                        state_d = ST_FIN;
                    else
                    begin
                        num_d   = bcd_to_bin(acc_q);
                        den_d   = bcd_to_bin(opnd);
                        rem_d   = '0;
                        cnt_d   = 6'(`ALU_DIV_STEPS);
                        state_d = ST_DIV;
                    end
                end
            end
            ST_DIV:
            begin
                num_d = {num_q[ACC_W-2:0], 1'b0};
                if (rem_sh >= {1'b0, den_q})
                begin
                    rem_d    = ACC_W'(rem_sh - {1'b0, den_q});
                    num_d[0] = 1'b1;
                end
                else
                    rem_d = rem_sh[ACC_W-1:0];
                cnt_d = cnt_q - 6'd1;
                if (cnt_q == 6'd1)
                begin
                    acc_d   = bin_to_bcd(num_d);
                    stk_d   = bin_to_bcd(rem_d);
                    state_d = ST_FIN;
                end
            end
            ST_FIN:
            begin
                flg_d.result_zero_flag     = acc_q == '0;
                flg_d.result_negative_flag = acc_q[`ALU_SIGN_BIT];
                done_d  = 1'b1;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // state registers only
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state_q <= ST_IDLE;
            acc_q   <= '0;
            stk_q   <= '0;
            num_q   <= '0;
            den_q   <= '0;
            rem_q   <= '0;
            cnt_q   <= '0;
            flg_q   <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            acc_q   <= acc_d;
            stk_q   <= stk_d;
            num_q   <= num_d;
            den_q   <= den_d;
            rem_q   <= rem_d;
            cnt_q   <= cnt_d;
            flg_q   <= flg_d;
            done_q  <= done_d;
        end
    end

    assign o_busy   = state_q != ST_IDLE;
    assign o_done   = done_q;
    assign o_acc    = acc_q;
    assign o_stack0 = stk_q;
    assign o_flags  = flg_q;

    chk_zero_flag_acc: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        o_done |-> o_flags.result_zero_flag == (o_acc == '0))
        else $error("zero flag disagrees with accumulator");
    chk_neg_flag_acc: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        o_done |-> o_flags.result_negative_flag == o_acc[`ALU_SIGN_BIT])
        else $error("negative flag disagrees with accumulator");
    chk_mul_two_cycles: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && i_start && i_op == OP_REAL_MUL) |-> ##2 o_done)
        else $error("real multiply did not finish in two cycles");
    chk_valid_real: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && i_start && i_op == OP_REAL_MUL) |=> o_flags.valid_real_flag
            == (o_acc[30:23] != `ALU_EXP_MAX))
        else $error("valid real flag wrong");
    chk_no_sign_err: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && i_start && i_op == OP_REAL_MUL) |=> !o_flags.sign_error_flag)
        else $error("sign error set by multiply");
    // both divide forms, so the 16-bit zero-divisor case reaches it too
    chk_div_zero_hold: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && i_start && (i_op == OP_BCD_DIV || i_op == OP_BCD_DIV_WIDE)
         && opnd == '0) |=> (o_flags.operand_overflow_flag && $stable(o_acc)))
        else $error("divide by zero changed accumulator");
    chk_div_latency: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (state_q == ST_IDLE && state_d == ST_DIV) |-> ##34 o_done)
        else $error("divide latency wrong");
    chk_flags_hold: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && !i_start) |=> $stable(o_flags))
        else $error("flags changed without an operation");
    chk_bad_bcd: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (!o_busy && i_start && (i_op == OP_BCD_DIV || i_op == OP_BCD_DIV_WIDE)
         && (!is_bcd(o_acc) || !is_bcd(opnd))) |=> o_flags.bad_number_flag)
        else $error("non-bcd operand not flagged");
endmodule : real_mul_bcd_div_alu

// ==== test/seq_model.sv ====
/*
 * sequencer model: issues one alu op and holds op and operand until done.
 * assumes one clock and the alu's start/done handshake.
 */
`timescale 1ns/10ps
module seq_model
    import alu_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_done,
    output alu_op_e   o_op,
    output operand_s  o_operand,
    output logic      o_start
);
    // idle values from time zero
    initial
    begin
        o_start = 1'b0;
        o_op = OP_NONE;
        o_operand = '0;
    end

    // start pulse, op held to done; lat counts edges from start to done
    task automatic issue(input alu_op_e op, input operand_s od, input int stall,
                         output int lat);
        operand_s held;
        held = od;
        if (op == OP_BCD_DIV_WIDE)
            held.is_const = 1'b0;
        repeat (stall) @(posedge i_core_clk);
        o_start   <= 1'b1;
        o_op      <= op;
        o_operand <= held;
        lat = 0;
        @(posedge i_core_clk);
        o_start <= 1'b0;
        do
        begin
            @(posedge i_core_clk);
            lat++;
        end while (i_done !== 1'b1 && lat < 100);
        // released operand shows the inverse so a stale read is caught
        o_operand <= ~held;
        o_op      <= OP_NONE;
    endtask : issue
endmodule : seq_model

// ==== test/real_mul_bcd_div_alu_tb.sv ====
/*
 * testbench for the arithmetic unit: table of ops, then flag hold,
 * back-to-back and mid-run reset cases. assumes seq_model as sequencer.
 */
`timescale 1ns/10ps
module real_mul_bcd_div_alu_tb
    import alu_pkg::*;
;
    typedef struct {
        alu_op_e     op;
        logic [31:0] acc;
        logic [31:0] opnd;
        logic        ptr;
        logic [31:0] e_acc;
        logic [31:0] e_stk;
        logic [7:0]  e_fl;
        logic [7:0]  m_fl;
    } row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        acc_load = 1'b0;
    logic [31:0] acc_val = 32'h0;
    logic        start;
    alu_op_e     op;
    operand_s    opnd;
    logic        busy;
    logic        done;
    logic [31:0] acc;
    logic [31:0] stk;
    flags_s      flags;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          lat;
    int          e_lat;
    logic [7:0]  fl;

    // flags: ovf zero neg ptr valid signerr under bad
    row_t rows [11] = '{
        '{OP_REAL_MUL, 32'h3F800000, 32'h40000000, 1'b0, 32'h40000000, 32'h0, 8'h08, 8'hFF},
        '{OP_REAL_MUL, 32'hC0400000, 32'h40000000, 1'b0, 32'hC0C00000, 32'h0, 8'h28, 8'hFF},
        '{OP_REAL_MUL, 32'h0, 32'h40000000, 1'b0, 32'h0, 32'h0, 8'h48, 8'hFF},
        '{OP_REAL_MUL, 32'h00800000, 32'h3F000000, 1'b0, 32'h0, 32'h0, 8'h4A, 8'hFF},
        '{OP_REAL_MUL, 32'h3F800000, 32'h7FC00000, 1'b0, 32'h3F800000, 32'h0, 8'h01, 8'hF1},
        '{OP_BCD_DIV, 32'h100, 32'h99990007, 1'b0, 32'h14, 32'h2, 8'h00, 8'hF1},
        '{OP_BCD_DIV_WIDE, 32'h12345678, 32'h00010000, 1'b0, 32'h1234, 32'h5678, 8'h00, 8'hF1},
        '{OP_BCD_DIV, 32'h50, 32'h0, 1'b0, 32'h50, 32'h0, 8'h80, 8'hF1},
        '{OP_BCD_DIV, 32'h50, 32'hA, 1'b0, 32'h50, 32'h0, 8'h01, 8'hF1},
        '{OP_BCD_DIV, 32'h50, 32'h5, 1'b1, 32'h50, 32'h0, 8'h10, 8'hF1},
        '{OP_BCD_DIV_WIDE, 32'h99, 32'h3, 1'b1, 32'h33, 32'h0, 8'h00, 8'hF1}
    };

    always #12.5 clk = ~clk;

    real_mul_bcd_div_alu u_real_mul_bcd_div_alu (
        .i_core_clk       (clk),
        .i_reset          (rst),
        .i_start          (start),
        .i_op             (op),
        .i_operand        (opnd),
        .i_acc_load       (acc_load),
        .i_acc_load_value (acc_val),
        .o_busy           (busy),
        .o_done           (done),
        .o_acc            (acc),
        .o_stack0         (stk),
        .o_flags          (flags)
    );

    seq_model u_seq_model (
        .i_core_clk (clk),
        .i_done     (done),
        .o_op       (op),
        .o_operand  (opnd),
        .o_start    (start)
    );

    // counted comparison, reports at once on mismatch
    task automatic chk(input bit ok, input string what);
        cmp_count++;
        if (!ok)
        begin
            fail_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk

    // verdict; also reached from the hang limit
    task automatic test_done;
        $display("checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // one idle cycle of accumulator load
    task automatic load(input logic [31:0] v);
        acc_load <= 1'b1;
        acc_val  <= v;
        @(posedge clk);
        acc_load <= 1'b0;
    endtask : load

    // the whole run needs well under 1000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({busy, done, acc, stk, flags} === 74'h0, "reset values");
        foreach (rows[k])
        begin
            load(rows[k].acc);
            u_seq_model.issue(rows[k].op, '{rows[k].opnd[15:0], rows[k].opnd[31:16],
                              1'b0, rows[k].ptr, rows[k].ptr}, 0, lat);
            fl = flags;
            // error cases answer early and keep the accumulator
            e_lat = (rows[k].op != OP_REAL_MUL && (rows[k].e_fl & 8'h91) == 8'h0) ? 34 : 2;
            chk(lat === e_lat, "done latency");
            chk(acc === rows[k].e_acc, "accumulator");
            chk((fl & rows[k].m_fl) === (rows[k].e_fl & rows[k].m_fl), "flags");
            if (e_lat == 34 || rows[k].op == OP_REAL_MUL)
                chk(stk === rows[k].e_stk, "stack location");
        end
        // idle cycles must not disturb the flags
        fl = flags;
        repeat (5) @(posedge clk);
        chk(flags === fl, "flags held while idle");
        // back-to-back multiplies, second after a stall
        load(32'h3F800000);
        u_seq_model.issue(OP_REAL_MUL, '{16'h0, 16'h4000, 1'b1, 1'b0, 1'b0}, 0, lat);
        u_seq_model.issue(OP_REAL_MUL, '{16'h0, 16'h4000, 1'b1, 1'b0, 1'b0}, 3, lat);
        chk(acc === 32'h40800000 && lat === 2, "chained product");
        chk(flags.result_zero_flag === 1'b0 && flags.valid_real_flag === 1'b1,
            "flags overwritten");
        // reset in mid-divide abandons it; done never comes, model gives up
        load(32'h99);
        fork
            u_seq_model.issue(OP_BCD_DIV_WIDE, '{16'h3, 16'h0, 1'b0, 1'b0, 1'b0}, 0, lat);
        join_none
        repeat (5) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(busy === 1'b0 && acc === 32'h0 && flags === 8'h0, "mid-run reset");
        wait fork;
        chk(lat === 100 && acc === 32'h0 && stk === 32'h0, "abandoned divide");
        test_done();
    end
endmodule : real_mul_bcd_div_alu_tb
